//--- logic/hcr_config_reg.v
// Operation
// - bit 15 selects synchronous reads; reset gives asynchronous
// - bits 14:12 set first-word latency 3..7; codes 0..2 reserved
// - after reset latency reads 4 and high clock select reads 0
// - bits 11:9 select burst length: continuous,4,8,16,32,1K; 6,7 reserved
// - burst length applies to linear, wrap reads and linear writes
// - continuous gives up to 1K words, or page count in block read
// - block reads still honour fixed burst lengths
// - bit 8 zero applies error correction, one bypasses it
// - bit 7 one drives ready pin high for ready, zero low
// - bit 6 one: interrupt pin low busy, high ready; zero inverted
// - ready and interrupt pins float until bit 5 is set
// - bit 5 clears on cold reset or by host writing zero
// - bit 4 zero: ready one clock before data; one: with data
// - bit 2 enables operation above 66 MHz; reset zero
// - bits 3 and 0 read-only; reset value 40C0h
// - bit 1 selects synchronous writes; sync write with async read reserved
// - bit 0 always reads zero, boot buffer locked
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "hcr_defs.vh"

module hcr_config_reg (
  input  wire        clock_i,          // 125 MHz system clock
  input  wire        reset_i,          // synchronous cold reset, active high
  input  wire [17:0] s_axi_awaddr_i,   // write address
  input  wire        s_axi_awvalid_i,  // write address valid
  output reg         s_axi_awready_o,  // write address ready
  input  wire [31:0] s_axi_wdata_i,    // write data
  input  wire [3:0]  s_axi_wstrb_i,    // write strobes
  input  wire        s_axi_wvalid_i,   // write data valid
  output reg         s_axi_wready_o,   // write data ready
  output reg  [1:0]  s_axi_bresp_o,    // write response
  output reg         s_axi_bvalid_o,   // write response valid
  input  wire        s_axi_bready_i,   // write response ready
  input  wire [17:0] s_axi_araddr_i,   // read address
  input  wire        s_axi_arvalid_i,  // read address valid
  output reg         s_axi_arready_o,  // read address ready
  output reg  [31:0] s_axi_rdata_o,    // read data
  output reg  [1:0]  s_axi_rresp_o,    // read response
  output reg         s_axi_rvalid_o,   // read data valid
  input  wire        s_axi_rready_i,   // read data ready
  input  wire        core_busy_i,      // device core busy (interrupt bit low)
  input  wire        data_ready_i,     // burst data valid next cycle
  output reg         ready_pin_o,      // ready pin output level
  output reg         ready_pin_oe_n_o, // ready pin enable, low drives
  output reg         compl_pin_o,      // completion pin output level
  output reg         compl_pin_oe_n_o, // completion pin enable, low drives
  output reg         read_timing_select_o,  // synchronous reads
  output reg         write_timing_select_o, // synchronous writes
  output reg  [2:0]  latency_cycles_o,      // first-word latency in cycles
  output reg  [10:0] burst_words_o,         // burst length, zero = continuous
  output reg         ecc_bypass_o,          // correction bypassed
  output reg         high_clock_select_o,   // above 66 MHz operation
  output reg         mode_reserved_o        // reserved mode combination chosen
);

  // ***********************************************************
  // configuration storage
  // ***********************************************************
  reg  [15:0] cfg_ff;
  reg  [15:0] nxt_cfg;
  reg  [17:0] awaddr_ff;
  reg  [31:0] wdata_ff;
  reg  [3:0]  wstrb_ff;
  reg         aw_have_ff;
  reg         w_have_ff;
  reg         ready_lvl_ff;

  wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
  wire w_take  = s_axi_wvalid_i & s_axi_wready_o;
  wire wr_go   = aw_have_ff & w_have_ff & ~s_axi_bvalid_o;
  // only the word index is decoded, so the low two byte-address bits are ignored
  wire wr_hit  = (awaddr_ff[17:2] == `HCR_IDX_SYSCFG1);
  wire rd_hit  = (s_axi_araddr_i[17:2] == `HCR_IDX_SYSCFG1);

  // byte-lane merge; only writable bits may change
  always @* begin
    nxt_cfg = cfg_ff;
    if (wstrb_ff[0])
      nxt_cfg[7:0] = wdata_ff[7:0];
    if (wstrb_ff[1])
      nxt_cfg[15:8] = wdata_ff[15:8];
    nxt_cfg = (nxt_cfg & `HCR_WR_MASK) | (cfg_ff & ~`HCR_WR_MASK);
  end

  // ***********************************************************
  // write channel
  // ***********************************************************
  reg         nxt_awready;
  reg         nxt_wready;
  reg         nxt_bvalid;
  reg  [1:0]  nxt_bresp;
  reg         nxt_aw_have;
  reg         nxt_w_have;
  wire        b_done = s_axi_bvalid_o & s_axi_bready_i;

  always @* begin
    nxt_awready = ~aw_have_ff & ~aw_take;
    nxt_wready  = ~w_have_ff & ~w_take;
    nxt_aw_have = aw_have_ff | aw_take;
    nxt_w_have  = w_have_ff | w_take;
    nxt_bvalid  = s_axi_bvalid_o;
    nxt_bresp   = s_axi_bresp_o;
    if (wr_go) begin
      nxt_bvalid  = 1'b1;
      nxt_bresp   = wr_hit ? `HCR_RESP_OKAY : `HCR_RESP_SLVERR;
      nxt_aw_have = 1'b0;
      nxt_w_have  = 1'b0;
    end else if (b_done) begin
      nxt_bvalid = 1'b0;
    end
    // both channels stay closed until the response is accepted, so one write at a time
    if (wr_go | s_axi_bvalid_o) begin
      nxt_awready = b_done;
      nxt_wready  = b_done;
    end
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      cfg_ff          <= `HCR_RESET_VAL;
      aw_have_ff      <= 1'b0;
      w_have_ff       <= 1'b0;
      awaddr_ff       <= {`HCR_ADDR_W{1'b0}};
      wdata_ff        <= 32'h00000000;
      wstrb_ff        <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `HCR_RESP_OKAY;
    end else begin
      s_axi_awready_o <= nxt_awready;
      s_axi_wready_o  <= nxt_wready;
      s_axi_bvalid_o  <= nxt_bvalid;
      s_axi_bresp_o   <= nxt_bresp;
      aw_have_ff      <= nxt_aw_have;
      w_have_ff       <= nxt_w_have;
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr_i;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end
      // an unmapped write is answered with an error and stores nothing
      if (wr_go & wr_hit) begin
        cfg_ff <= nxt_cfg;
      end
    end
  end

  // ***********************************************************
  // read channel
  // ***********************************************************
  reg         nxt_arready;
  reg         nxt_rvalid;
  reg  [31:0] nxt_rdata;
  reg  [1:0]  nxt_rresp;
  wire        ar_take = s_axi_arvalid_i & s_axi_arready_o;

  always @* begin
    nxt_arready = s_axi_arready_o;
    nxt_rvalid  = s_axi_rvalid_o;
    nxt_rdata   = s_axi_rdata_o;
    nxt_rresp   = s_axi_rresp_o;
    if (s_axi_rvalid_o) begin
      // address channel reopens only once the data has been taken
      nxt_arready = s_axi_rready_i;
      if (s_axi_rready_i) begin
        nxt_rvalid = 1'b0;
      end
    end else if (ar_take) begin
      nxt_arready = 1'b0;
      nxt_rvalid  = 1'b1;
      nxt_rdata   = rd_hit ? {16'h0000, cfg_ff} : 32'h00000000;
      nxt_rresp   = rd_hit ? `HCR_RESP_OKAY : `HCR_RESP_SLVERR;
    end else begin
      nxt_arready = 1'b1;
    end
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h00000000;
      s_axi_rresp_o   <= `HCR_RESP_OKAY;
    end else begin
      s_axi_arready_o <= nxt_arready;
      s_axi_rvalid_o  <= nxt_rvalid;
      s_axi_rdata_o   <= nxt_rdata;
      s_axi_rresp_o   <= nxt_rresp;
    end
  end

  // ***********************************************************
  // decoded mode outputs
  // ***********************************************************
  reg         nxt_read_timing_select;
  reg         nxt_write_timing_select;
  reg  [2:0]  nxt_latency_cycles;
  reg  [10:0] nxt_burst_words;
  reg         nxt_ecc_bypass;
  reg         nxt_high_clock_select;
  reg         nxt_mode_reserved;
  wire [2:0]  lat_code  = cfg_ff[`HCR_LAT_HI:`HCR_LAT_LO];
  wire [2:0]  bsz_code  = cfg_ff[`HCR_BSZ_HI:`HCR_BSZ_LO];
  wire        lat_res   = (lat_code < `HCR_LAT_MIN);
  wire        bsz_res   = (bsz_code > `HCR_BSZ_1K);
  wire        wr_rd_res = cfg_ff[`HCR_WTS_BIT] & ~cfg_ff[`HCR_RTS_BIT];

  always @* begin
    nxt_read_timing_select  = cfg_ff[`HCR_RTS_BIT];
    nxt_write_timing_select = cfg_ff[`HCR_WTS_BIT];
    // reserved latency codes fall back to the shortest legal value
    if (lat_res) begin
      nxt_latency_cycles = `HCR_LAT_MIN;
    end else begin
      nxt_latency_cycles = lat_code;
    end
    case (bsz_code)
      `HCR_BSZ_4:  nxt_burst_words = `HCR_LEN_4;
      `HCR_BSZ_8:  nxt_burst_words = `HCR_LEN_8;
      `HCR_BSZ_16: nxt_burst_words = `HCR_LEN_16;
      `HCR_BSZ_32: nxt_burst_words = `HCR_LEN_32;
      `HCR_BSZ_1K: nxt_burst_words = `HCR_LEN_1K;
      // continuous: the burst engine runs to 1K or the page count
      default:     nxt_burst_words = `HCR_LEN_NONE;
    endcase
    nxt_ecc_bypass        = cfg_ff[`HCR_ECC_BIT];
    nxt_high_clock_select = cfg_ff[`HCR_HF_BIT];
    // flagged, not blocked: the register keeps what the host wrote
    nxt_mode_reserved     = wr_rd_res | bsz_res | lat_res;
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      read_timing_select_o  <= 1'b0;
      write_timing_select_o <= 1'b0;
      latency_cycles_o      <= `HCR_LAT_RESET;
      burst_words_o         <= `HCR_LEN_NONE;
      ecc_bypass_o          <= 1'b0;
      high_clock_select_o   <= 1'b0;
      mode_reserved_o       <= 1'b0;
    end else begin
      read_timing_select_o  <= nxt_read_timing_select;
      write_timing_select_o <= nxt_write_timing_select;
      latency_cycles_o      <= nxt_latency_cycles;
      burst_words_o         <= nxt_burst_words;
      ecc_bypass_o          <= nxt_ecc_bypass;
      high_clock_select_o   <= nxt_high_clock_select;
      mode_reserved_o       <= nxt_mode_reserved;
    end
  end

  // ***********************************************************
  // ready and completion pins
  // ***********************************************************
  reg         nxt_ready_pin;
  reg         nxt_compl_pin;
  reg         nxt_pins_oe_n;
  wire        ready_src = cfg_ff[`HCR_RTIM_BIT] ? ready_lvl_ff : data_ready_i;

  // with timing bit clear the pin leads the data by the one-cycle look-ahead
  always @* begin
    nxt_ready_pin = ~ready_src ^ cfg_ff[`HCR_RPOL_BIT];
    nxt_compl_pin = ~core_busy_i ^ ~cfg_ff[`HCR_CPOL_BIT];
    // levels are computed always; only the enable decides whether the host sees them
    nxt_pins_oe_n = ~cfg_ff[`HCR_OE_BIT];
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      ready_lvl_ff     <= 1'b0;
      ready_pin_o      <= 1'b0;
      compl_pin_o      <= 1'b0;
      ready_pin_oe_n_o <= 1'b1;
      compl_pin_oe_n_o <= 1'b1;
    end else begin
      ready_lvl_ff     <= data_ready_i;
      ready_pin_o      <= nxt_ready_pin;
      compl_pin_o      <= nxt_compl_pin;
      ready_pin_oe_n_o <= nxt_pins_oe_n;
      compl_pin_oe_n_o <= nxt_pins_oe_n;
    end
  end

endmodule

//--- logic/hcr_defs.vh
`ifndef HCR_DEFS_VH
`define HCR_DEFS_VH

// ***********************************************************
// register map
// ***********************************************************
`define HCR_IDX_SYSCFG1     16'hF221
`define HCR_ADDR_SYSCFG1    18'h3C884
`define HCR_ADDR_STATUS     18'h00000
`define HCR_ADDR_W          18
`define HCR_RESET_VAL       16'h40C0
`define HCR_WR_MASK         16'hFFF6

// ***********************************************************
// field positions
// ***********************************************************
`define HCR_RTS_BIT         15
`define HCR_LAT_HI          14
`define HCR_LAT_LO          12
`define HCR_BSZ_HI          11
`define HCR_BSZ_LO          9
`define HCR_ECC_BIT         8
`define HCR_RPOL_BIT        7
`define HCR_CPOL_BIT        6
`define HCR_OE_BIT          5
`define HCR_RTIM_BIT        4
`define HCR_HF_BIT          2
`define HCR_WTS_BIT         1

// ***********************************************************
// encodings
// ***********************************************************
`define HCR_LAT_MIN         3'h3
`define HCR_LAT_RESET       3'h4
`define HCR_BSZ_CONT        3'h0
`define HCR_BSZ_4           3'h1
`define HCR_BSZ_8           3'h2
`define HCR_BSZ_16          3'h3
`define HCR_BSZ_32          3'h4
`define HCR_BSZ_1K          3'h5
`define HCR_LEN_4           11'h004
`define HCR_LEN_8           11'h008
`define HCR_LEN_16          11'h010
`define HCR_LEN_32          11'h020
`define HCR_LEN_1K          11'h400
`define HCR_LEN_NONE        11'h000
`define HCR_RESP_OKAY       2'h0
`define HCR_RESP_SLVERR     2'h2

`endif

//--- testbench/hcr_config_reg_sva.sv
`timescale 1ns/1ps
`include "hcr_defs.vh"
module hcr_config_reg_sva (
  input wire logic        clock_i, reset_i, s_axi_awvalid_i, s_axi_awready_o,
  input wire logic        s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o,
  input wire logic        s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o,
  input wire logic [17:0] s_axi_araddr_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        ready_pin_oe_n_o, compl_pin_oe_n_o, mode_reserved_o,
  input wire logic        read_timing_select_o, write_timing_select_o,
  input wire logic [2:0]  latency_cycles_o,
  input wire logic [10:0] burst_words_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // ****
  // checks
  // ****
  AST_RST_DEF: assert property ($fell(reset_i) |-> ready_pin_oe_n_o &&
    latency_cycles_o == 3'h4 && burst_words_o == 11'h000) else $error("bad reset state");
  AST_OE_PAIR: assert property (ready_pin_oe_n_o == compl_pin_oe_n_o)
    else $error("pin enables differ");
  AST_B_SOON: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
    s_axi_wready_o |-> ##[1:3] s_axi_bvalid_o) else $error("no write response");
  AST_R_SOON: assert property (s_axi_arvalid_i && s_axi_arready_o |->
    ##[1:2] s_axi_rvalid_o) else $error("no read data");
  AST_R_BAD: assert property (s_axi_arvalid_i && s_axi_arready_o &&
    s_axi_araddr_i[17:2] != `HCR_IDX_SYSCFG1 |-> ##[1:2] s_axi_rvalid_o && s_axi_rresp_o == 2'h2)
    else $error("unmapped read not refused");
  AST_R_FIXED: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000 &&
    !s_axi_rdata_o[3] && !s_axi_rdata_o[0]) else $error("fixed bits not zero");
  AST_LAT_MIN: assert property (latency_cycles_o >= 3'h3)
    else $error("latency below three");
  AST_BURST: assert property (burst_words_o inside {11'h000, 11'h004, 11'h008,
    11'h010, 11'h020, 11'h400}) else $error("illegal burst length");
  AST_MODE_RES: assert property (write_timing_select_o && !read_timing_select_o |->
    mode_reserved_o) else $error("reserved mode not flagged");
  COV_WR: cover property (s_axi_bvalid_o);
  COV_BAD: cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'h2);
  COV_PINS: cover property (!ready_pin_oe_n_o);
endmodule
bind hcr_config_reg hcr_config_reg_sva u_sva (.*);

//--- testbench/hcr_host_pins.sv
`timescale 1ns/1ps
module hcr_host_pins (
  input  wire logic clock_i,                         // bus clock
  input  wire logic rdy_i, rdy_oe_n_i, int_i, int_oe_n_i, // device pin drivers
  output wire logic rdy_o, int_o                     // levels the host sees
);
  logic rdy_ff = 1'b0;
  logic int_ff = 1'b0;
  always @(posedge clock_i) begin
    if (!rdy_oe_n_i) rdy_ff <= rdy_i;
    if (!int_oe_n_i) int_ff <= int_i;
  end
  // a floating pin shows the inverse of its last level, so a float never passes as valid
  assign rdy_o = rdy_oe_n_i ? ~rdy_ff : rdy_i;
  assign int_o = int_oe_n_i ? ~int_ff : int_i;
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
`include "hcr_defs.vh"
module tb;
  logic        clock_i = 1'b0, reset_i = 1'b1, core_busy_i = 1'b0, data_ready_i = 1'b0;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [17:0] s_axi_awaddr_i = 18'h00000, s_axi_araddr_i = 18'h00000;
  logic [31:0] s_axi_wdata_i = 32'h00000000, rd;
  logic [3:0]  s_axi_wstrb_i = 4'hF;
  logic [1:0]  rsp;
  logic [15:0] c;
  wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  wire         s_axi_rvalid_o, ready_pin_o, ready_pin_oe_n_o, compl_pin_o, compl_pin_oe_n_o;
  wire         read_timing_select_o, write_timing_select_o, ecc_bypass_o, high_clock_select_o;
  wire         mode_reserved_o, host_rdy, host_int;
  wire [1:0]   s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0]  s_axi_rdata_o;
  wire [2:0]   latency_cycles_o;
  wire [10:0]  burst_words_o;
  logic [10:0] blen [8] = '{11'h0, 11'h4, 11'h8, 11'h10, 11'h20, 11'h400, 11'h0, 11'h0};
  logic [15:0] pcfg [3] = '{16'h40E0, 16'h40F0, 16'h4020};
  int          error_cnt = 0;
  int          tests_run = 0;
  hcr_config_reg uut (.*);
  hcr_host_pins u_host (.clock_i(clock_i), .rdy_i(ready_pin_o), .rdy_oe_n_i(ready_pin_oe_n_o),
    .int_i(compl_pin_o), .int_oe_n_i(compl_pin_oe_n_o), .rdy_o(host_rdy), .int_o(host_int));
  initial forever #4 clock_i = ~clock_i;
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [17:0] a, input logic [15:0] d);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {16'h0000, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o);
    rsp = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task rd16(input logic [17:0] a);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o);
    rd = s_axi_rdata_o;
    rsp = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task drv(input logic b, input logic r);
    core_busy_i <= b;
    data_ready_i <= r;
    @(posedge clock_i);
  endtask
  task give_verdict;
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // run is about 110 cycles; this limit leaves ample room
  initial begin
    #100000;
    error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    chk({ready_pin_oe_n_o, compl_pin_oe_n_o}, 2'h3);
    chk({read_timing_select_o, write_timing_select_o, ecc_bypass_o, high_clock_select_o}, 4'h0);
    rd16(`HCR_ADDR_SYSCFG1);
    chk(rd, 32'h000040C0);
    chk(rsp, 2'h0);
    wr(`HCR_ADDR_SYSCFG1, 16'hFFFF);
    chk(rsp, 2'h0);
    rd16(`HCR_ADDR_SYSCFG1);
    chk(rd, 32'h0000FFF6);
    chk({read_timing_select_o, write_timing_select_o, ecc_bypass_o, high_clock_select_o}, 4'hF);
    for (int i = 0; i < 8; i++) begin
      wr(`HCR_ADDR_SYSCFG1, {1'b1, i[2:0], i[2:0], 9'h000});
      chk(latency_cycles_o, (i < 3) ? 3 : i);
      chk(burst_words_o, blen[i]);
      chk(mode_reserved_o, (i < 3 || i > 5) ? 1 : 0);
    end
    wr(`HCR_ADDR_SYSCFG1, 16'hE004);
    chk({high_clock_select_o, latency_cycles_o}, 4'hE);
    wr(`HCR_ADDR_SYSCFG1, 16'hD000);
    chk({high_clock_select_o, latency_cycles_o}, 4'h5);
    wr(`HCR_ADDR_SYSCFG1, 16'h4002);
    chk(mode_reserved_o, 1'h1);
    for (int k = 0; k < 3; k++) begin
      c = pcfg[k];
      wr(`HCR_ADDR_SYSCFG1, c);
      drv(1'b1, 1'b0);
      drv(1'b1, 1'b0);
      chk(host_int, !c[6]);
      drv(1'b0, 1'b1);
      drv(1'b0, 1'b0);
      chk(host_rdy, c[7] ^ c[4]);
      drv(1'b0, 1'b0);
      chk(host_rdy, c[7] ^ !c[4]);
      chk(host_int, c[6]);
    end
    wr(`HCR_ADDR_STATUS, 16'h0000);
    chk(rsp, 2'h2);
    rd16(`HCR_ADDR_STATUS);
    chk(rsp, 2'h2);
    chk(rd, 32'h00000000);
    rd16(`HCR_ADDR_SYSCFG1);
    chk(rd, 32'h00004020);
    wr(`HCR_ADDR_SYSCFG1, 16'h40C0);
    chk({ready_pin_oe_n_o, compl_pin_oe_n_o}, 2'h3);
    wr(`HCR_ADDR_SYSCFG1, 16'h40E0);
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    rd16(`HCR_ADDR_SYSCFG1);
    chk(ready_pin_oe_n_o, 1'h1);
    chk(rd, 32'h000040C0);
    give_verdict;
  end
endmodule
